// ---- bench/pci_master_model.sv ----
`timescale 1ns/1ns
module pci_master_model (
  input  wire logic        i_clk,
  output logic             o_valid,
  output logic             o_is_io,
  output logic             o_is_mem,
  output logic      [31:0] o_addr
);
  initial
  begin
    o_valid  = 1'b0;
    o_is_io  = 1'b0;
    o_is_mem = 1'b0;
    o_addr   = 32'h0000_0000;
  end

  // Held for one clock; callers chain these back to back
  task automatic issue(input logic io, input logic [31:0] a);
    o_valid  = 1'b1;
    o_is_io  = io;
    o_is_mem = ~io;
    o_addr   = a;
    @(posedge i_clk);
    #1;
  endtask : issue

  // Released bus shows the inverse so a stale address never matches
  task automatic idle;
    o_valid  = 1'b0;
    o_is_io  = 1'b0;
    o_is_mem = 1'b0;
    o_addr   = ~o_addr;
  endtask : idle
endmodule : pci_master_model

// ---- bench/tb_top.sv ----
`timescale 1ns/1ns
module tb_top;
  logic        i_clk, i_rst_b, i_cfg_wr, i_cfg_rd, i_eio_fwd_en, i_trap_en;
  logic        i_cyc_valid, i_cyc_is_io, i_cyc_is_mem, o_cfg_ack;
  logic        o_io_hit, o_io_fwd, o_io_trap, o_mem_hit, o_mem_fwd, o_mem_trap;
  logic [7:0]  i_cfg_addr;
  logic [3:0]  i_cfg_be;
  logic [31:0] i_cfg_wdata, i_cyc_addr, o_cfg_rdata, io_m, mem_m, a, r, d;
  logic        io, e_io, e_mem;
  int          fails, checked, seed, k, n;
  range_decode_pkg::io_range_decode_cfg_t  ic;
  range_decode_pkg::mem_range_decode_cfg_t mc;

  always #50 i_clk = ~i_clk;

  dev12_range_decoder uut (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_cfg_wr(i_cfg_wr), .i_cfg_rd(i_cfg_rd), .i_cfg_addr(i_cfg_addr),
    .i_cfg_be(i_cfg_be), .i_cfg_wdata(i_cfg_wdata),
    .i_cyc_valid(i_cyc_valid), .i_cyc_is_io(i_cyc_is_io),
    .i_cyc_is_mem(i_cyc_is_mem), .i_cyc_addr(i_cyc_addr),
    .i_eio_fwd_en(i_eio_fwd_en), .i_trap_en(i_trap_en),
    .o_cfg_rdata(o_cfg_rdata), .o_cfg_ack(o_cfg_ack), .o_io_hit(o_io_hit),
    .o_io_fwd(o_io_fwd), .o_io_trap(o_io_trap), .o_mem_hit(o_mem_hit),
    .o_mem_fwd(o_mem_fwd), .o_mem_trap(o_mem_trap));

  pci_master_model u_pci (.i_clk(i_clk), .o_valid(i_cyc_valid),
    .o_is_io(i_cyc_is_io), .o_is_mem(i_cyc_is_mem), .o_addr(i_cyc_addr));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic give_verdict;
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict

  task automatic cfg_wr(input logic [7:0] ad, input logic [3:0] be,
                        input logic [31:0] dt);
    i_cfg_wr    = 1'b1;
    i_cfg_addr  = ad;
    i_cfg_be    = be;
    i_cfg_wdata = dt;
    for (n = 0; n < 4; n++)
      if (be[n])
      begin
        if (ad == 8'h68) io_m[8*n+:8] = dt[8*n+:8];
        if (ad == 8'h6C) mem_m[8*n+:8] = dt[8*n+:8];
      end
    io_m  = io_m & 32'h001F_FFFF;
    mem_m = mem_m & 32'hFFFF_80FF;
    @(posedge i_clk);
    #1;
    i_cfg_wr = 1'b0;
    // One idle edge so a following write never re-raises the strobe at once
    @(posedge i_clk);
    #1;
  endtask : cfg_wr

  task automatic cfg_rd(input logic [7:0] ad, input logic [31:0] exp);
    i_cfg_rd   = 1'b1;
    i_cfg_addr = ad;
    for (k = 0; k < 4; k++)
    begin
      @(posedge i_clk);
      #1;
      if (o_cfg_ack === 1'b1) break;
    end
    i_cfg_rd = 1'b0;
    if (k == 4)
    begin
      fails++;
      give_verdict();
    end
    chk(o_cfg_rdata, exp);
    @(posedge i_clk);
    #1;
  endtask : cfg_rd

  task automatic cyc(input logic t_io, input logic [31:0] ad);
    ic    = io_m[23:0];
    mc    = mem_m;
    e_io  = t_io && ic.io_monitor_enable && ((ad[15:0] ^ ic.io_range_base)
            & ~{12'h000, ic.io_range_mask}) == 16'h0000;
    e_mem = !t_io && mc.mem_monitor_enable && ((ad[31:15] ^ mc.mem_range_base)
            & ~{10'h000, mc.mem_range_mask}) == 17'h0_0000;
    u_pci.issue(t_io, ad);
    chk({o_io_hit, o_io_fwd, o_io_trap}, {e_io, e_io & i_eio_fwd_en,
        e_io & i_trap_en});
    chk({o_mem_hit, o_mem_fwd, o_mem_trap}, {e_mem, e_mem & i_eio_fwd_en,
        e_mem & i_trap_en});
  endtask : cyc

  initial
  begin
    {i_clk, i_rst_b, i_cfg_wr, i_cfg_rd, i_eio_fwd_en, i_trap_en} = 6'h00;
    {i_cfg_addr, i_cfg_be, i_cfg_wdata} = 44'h000_0000_0000;
    {io_m, mem_m, fails, checked, seed} = {64'h0, 32'h0, 32'h0, 32'd27476};
    repeat (2) @(posedge i_clk);
    #1;
    i_rst_b = 1'b1;
    repeat (3) @(posedge i_clk);
    #1;
    cfg_rd(8'h68, 32'h0000_0000);
    cfg_rd(8'h6C, 32'h0000_0000);
    cfg_wr(8'h68, 4'hF, 32'hFFFF_FFFF);
    cfg_wr(8'h6C, 4'hF, 32'hFFFF_FFFF);
    cfg_wr(8'h70, 4'hF, 32'hFFFF_FFFF);
    cfg_rd(8'h68, 32'h001F_FFFF);
    cfg_rd(8'h6C, 32'hFFFF_80FF);
    cfg_rd(8'h70, 32'h0000_0000);
    // Split-range patterns first, then random settings with random strobes
    cfg_wr(8'h68, 4'hF, 32'h0019_1234);
    cfg_wr(8'h6C, 4'hF, 32'h55E6_80F3);
    // Directed hits and misses inside the split ranges
    {i_eio_fwd_en, i_trap_en} = 2'b11;
    cyc(1'b1, 32'h0000_123D);
    cyc(1'b1, 32'h0000_1236);
    cyc(1'b0, 32'h55DE_0000);
    cyc(1'b0, 32'h55E4_8000);
    cyc(1'b0, 32'h45E6_8000);
    u_pci.idle();
    for (int p = 0; p < 16; p++)
    begin
      if (p > 0)
      begin
        r = $random(seed);
        d = $random(seed);
        cfg_wr(8'h68, r[3:0], d);
        d = $random(seed);
        cfg_wr(8'h6C, r[7:4], d);
      end
      cfg_rd(8'h68, io_m);
      cfg_rd(8'h6C, mem_m);
      for (int j = 0; j < 40; j++)
      begin
        r = $random(seed);
        a = $random(seed);
        {io, i_eio_fwd_en, i_trap_en} = r[31:29];
        if (j % 4 != 3 && io)
          a[15:0] = io_m[15:0] ^ (r[15:0] & {12'h000, io_m[19:16]});
        if (j % 4 != 3 && !io)
          a[31:15] = mem_m[31:15] ^ (r[16:0] & {10'h000, mem_m[6:0]});
        if (j % 4 == 2)
          a[io ? r[19:16] : 5'd15 + r[20:16] % 5'd17] ^= 1'b1;
        cyc(io, a);
      end
      u_pci.idle();
    end
    // Reset in mid-run must bring every field back to zero
    i_rst_b = 1'b0;
    {io_m, mem_m} = 64'h0;
    repeat (2) @(posedge i_clk);
    #1;
    i_rst_b = 1'b1;
    repeat (3) @(posedge i_clk);
    #1;
    cfg_rd(8'h68, 32'h0000_0000);
    cfg_rd(8'h6C, 32'h0000_0000);
    cyc(1'b1, 32'h0000_0000);
    cyc(1'b0, 32'h0000_0000);
    u_pci.idle();
    give_verdict();
  end
endmodule : tb_top

// ---- hdl/dev12_range_decoder.sv ----
// Summary of operation
// - I/O enable bit 20 gates I/O compare
// - I/O hit acts only with forward/trap enable
// - I/O mask bits 19:16 map to AD[3:0]
// - Mask one excludes bit; zero must match
// - I/O base bits 15:0 compare AD[15:0]
// - Non-contiguous I/O masks give split ranges
// - Memory base bits 31:15 compare AD[31:15]
// - Memory mask bits 6:0 map AD[21:15]
// - Memory enable bit 7 gates memory compare
// - Memory hit acts only with forward/trap enable
// - Non-contiguous memory masks give split ranges
`timescale 1ns/1ns
`include "range_decode_cfg.svh"
module dev12_range_decoder (
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_cfg_wr,
  input  wire logic        i_cfg_rd,
  input  wire logic [7:0]  i_cfg_addr,
  input  wire logic [3:0]  i_cfg_be,
  input  wire logic [31:0] i_cfg_wdata,
  input  wire logic        i_cyc_valid,
  input  wire logic        i_cyc_is_io,
  input  wire logic        i_cyc_is_mem,
  input  wire logic [31:0] i_cyc_addr,
  input  wire logic        i_eio_fwd_en,
  input  wire logic        i_trap_en,
  output logic      [31:0] o_cfg_rdata,
  output logic             o_cfg_ack,
  output logic             o_io_hit,
  output logic             o_io_fwd,
  output logic             o_io_trap,
  output logic             o_mem_hit,
  output logic             o_mem_fwd,
  output logic             o_mem_trap
);

  logic                                  rst_meta_reg;
  logic                                  rst_sync_reg;
  range_decode_pkg::io_range_decode_cfg_t  io_cfg_reg;
  range_decode_pkg::io_range_decode_cfg_t  io_cfg_next;
  range_decode_pkg::mem_range_decode_cfg_t mem_cfg_reg;
  range_decode_pkg::mem_range_decode_cfg_t mem_cfg_next;

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  wire rst_b = rst_sync_reg;

  // Configuration access decode
  wire        sel_io    = (i_cfg_addr[7:2] == 6'(`RD_IO_CFG_OFS  >> 2));
  wire        sel_mem   = (i_cfg_addr[7:2] == 6'(`RD_MEM_CFG_OFS >> 2));
  wire [31:0] be_bits   = {{8{i_cfg_be[3]}}, {8{i_cfg_be[2]}},
                           {8{i_cfg_be[1]}}, {8{i_cfg_be[0]}}};
  wire [31:0] io_wmask  = be_bits & `RD_IO_WR_MASK;
  wire [31:0] mem_wmask = be_bits & `RD_MEM_WR_MASK;
  wire [31:0] io_cur    = {8'h00, io_cfg_reg};
  wire [31:0] io_merged = (io_cur & ~io_wmask) | (i_cfg_wdata & io_wmask);
  wire [31:0] mem_merged = (mem_cfg_reg & ~mem_wmask)
                         | (i_cfg_wdata & mem_wmask);

  // Write masks keep reserved bits at zero
  assign io_cfg_next  = (i_cfg_wr && sel_io) ? io_merged[23:0]
                                             : io_cfg_reg;
  assign mem_cfg_next = (i_cfg_wr && sel_mem) ? mem_merged
                                              : mem_cfg_reg;

  // Unmapped offsets read as zero; a read in a write cycle sees old data
  wire [31:0] rd_sel = sel_io  ? io_cur :
                       sel_mem ? mem_cfg_reg : 32'h0000_0000;
  wire [31:0] rdata_next = i_cfg_rd ? rd_sel : o_cfg_rdata;

  always_ff @(posedge i_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      io_cfg_reg  <= `RD_IO_RESET;
      mem_cfg_reg <= `RD_MEM_RESET;
      o_cfg_rdata <= `RD_RDATA_RESET;
      o_cfg_ack   <= 1'b0;
    end
    else
    begin
      io_cfg_reg  <= io_cfg_next;
      mem_cfg_reg <= mem_cfg_next;
      o_cfg_rdata <= rdata_next;
      o_cfg_ack   <= i_cfg_rd;
    end
  end

  // Address compares; I/O upper address bits are taken as zero, not checked
  range_match_if #(.BW(`RD_IO_BASE_W),  .MW(`RD_IO_MASK_W))  io_if ();
  range_match_if #(.BW(`RD_MEM_BASE_W), .MW(`RD_MEM_MASK_W)) mem_if ();

  assign io_if.enable = i_cyc_valid && i_cyc_is_io
                     && io_cfg_reg.io_monitor_enable;
  assign io_if.base   = io_cfg_reg.io_range_base;
  assign io_if.addr   = i_cyc_addr[15:0];
  assign io_if.mask   = io_cfg_reg.io_range_mask;

  assign mem_if.enable = i_cyc_valid && i_cyc_is_mem
                      && mem_cfg_reg.mem_monitor_enable;
  assign mem_if.base   = mem_cfg_reg.mem_range_base;
  assign mem_if.addr   = i_cyc_addr[31:`RD_MEM_LSB];
  assign mem_if.mask   = mem_cfg_reg.mem_range_mask;

  range_match #(.BW(`RD_IO_BASE_W), .MW(`RD_IO_MASK_W)) u_io_match (
    .m (io_if.cmp)
  );

  range_match #(.BW(`RD_MEM_BASE_W), .MW(`RD_MEM_MASK_W)) u_mem_match (
    .m (mem_if.cmp)
  );

  // Each enable gates only its own function
  wire io_fwd_next   = io_if.hit  && i_eio_fwd_en;
  wire io_trap_next  = io_if.hit  && i_trap_en;
  wire mem_fwd_next  = mem_if.hit && i_eio_fwd_en;
  wire mem_trap_next = mem_if.hit && i_trap_en;

  always_ff @(posedge i_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      o_io_hit   <= 1'b0;
      o_io_fwd   <= 1'b0;
      o_io_trap  <= 1'b0;
      o_mem_hit  <= 1'b0;
      o_mem_fwd  <= 1'b0;
      o_mem_trap <= 1'b0;
    end
    else
    begin
      o_io_hit   <= io_if.hit;
      o_io_fwd   <= io_fwd_next;
      o_io_trap  <= io_trap_next;
      o_mem_hit  <= mem_if.hit;
      o_mem_fwd  <= mem_fwd_next;
      o_mem_trap <= mem_trap_next;
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!rst_b);

  wire io_cyc  = i_cyc_valid && i_cyc_is_io;
  wire mem_cyc = i_cyc_valid && i_cyc_is_mem;
  wire io_en   = io_cfg_reg.io_monitor_enable;
  wire mem_en  = mem_cfg_reg.mem_monitor_enable;
  wire [15:0] io_b  = io_cfg_reg.io_range_base;
  wire [3:0]  io_m  = io_cfg_reg.io_range_mask;
  wire [16:0] mem_b = mem_cfg_reg.mem_range_base;
  wire [6:0]  mem_m = mem_cfg_reg.mem_range_mask;

  AST_IO_HIT_NEEDS_ENABLE:
    assert property (o_io_hit |-> $past(io_cyc) && $past(io_en))
    else $error("I/O hit without enabled I/O cycle");

  AST_IO_ACT_GATED:
    assert property ((o_io_fwd |-> o_io_hit && $past(i_eio_fwd_en))
                     and (o_io_trap |-> o_io_hit && $past(i_trap_en)))
    else $error("I/O action without its own enable");

  AST_IO_FULL_MASK:
    assert property (io_cyc && io_en && io_m == 4'hF
                     && i_cyc_addr[15:4] == io_b[15:4] |=> o_io_hit)
    else $error("Fully masked low nibble did not hit");

  AST_IO_UNMASKED_MISS:
    assert property (io_cyc && io_m == 4'h0
                     && i_cyc_addr[15:0] != io_b |=> !o_io_hit)
    else $error("Unmasked mismatch gave I/O hit");

  AST_IO_EXACT_BASE:
    assert property (io_cyc && io_en && io_m == 4'h0
                     && i_cyc_addr[15:0] == io_b |=> o_io_hit)
    else $error("Exact I/O base did not hit");

  AST_IO_SPLIT:
    assert property (io_cyc && io_en && io_m == 4'h9
                     && i_cyc_addr[15:1] == (io_b[15:1] ^ 15'h0001)
                     |=> !o_io_hit)
    else $error("Split I/O mask hit on compared bit");

  AST_MEM_EXACT_BASE:
    assert property (mem_cyc && mem_en && mem_m == 7'h00
                     && i_cyc_addr[31:15] == mem_b |=> o_mem_hit)
    else $error("Exact memory base did not hit");

  AST_MEM_UPPER_CHECKED:
    assert property (mem_cyc && i_cyc_addr[31:22] != mem_b[16:7]
                     |=> !o_mem_hit)
    else $error("Memory bits above 21 were ignored");

  AST_MEM_HIT_NEEDS_ENABLE:
    assert property (o_mem_hit |-> $past(mem_cyc) && $past(mem_en))
    else $error("Memory hit without enabled memory cycle");

  AST_MEM_ACT_GATED:
    assert property ((o_mem_fwd |-> o_mem_hit && $past(i_eio_fwd_en))
                     and (o_mem_trap |-> o_mem_hit && $past(i_trap_en)))
    else $error("Memory action without its own enable");

  AST_MEM_SPLIT:
    assert property (mem_cyc && mem_en && mem_m == 7'h73
                     && i_cyc_addr[31:22] == mem_b[16:7]
                     && i_cyc_addr[18:17] == mem_b[3:2] |=> o_mem_hit)
    else $error("Split memory mask failed to hit");

  AST_RSVD_READ_ZERO:
    assert property (i_cfg_rd && !i_cfg_wr && sel_io |=>
                     o_cfg_ack && o_cfg_rdata[31:21] == 11'h000)
    else $error("Reserved I/O bits read non-zero");

  COV_IO_FWD:    cover property (o_io_fwd);
  COV_MEM_TRAP:  cover property (o_mem_trap);
  COV_IO_SPLIT:  cover property (io_m == 4'h9 ##1 o_io_hit);
  COV_CFG_WRITE: cover property (i_cfg_wr && sel_mem ##1 mem_en);

endmodule : dev12_range_decoder

// ---- hdl/range_decode_cfg.svh ----
`ifndef RANGE_DECODE_CFG_SVH
`define RANGE_DECODE_CFG_SVH

// Configuration-space byte offsets of the two decode registers
`define RD_IO_CFG_OFS    8'h68
`define RD_MEM_CFG_OFS   8'h6C

// Bits that software may change; reserved bits stay zero
`define RD_IO_WR_MASK    32'h001F_FFFF
`define RD_MEM_WR_MASK   32'hFFFF_80FF

// Reset values
`define RD_IO_RESET      24'h00_0000
`define RD_MEM_RESET     32'h0000_0000
`define RD_RDATA_RESET   32'h0000_0000

// Compare widths: I/O base spans AD[15:0], memory base spans AD[31:15]
`define RD_IO_BASE_W     16
`define RD_IO_MASK_W     4
`define RD_MEM_BASE_W    17
`define RD_MEM_MASK_W    7
`define RD_MEM_LSB       15

`endif

// ---- hdl/range_decode_pkg.sv ----
package range_decode_pkg;

  typedef struct packed {
    logic [2:0]  rsvd;
    logic        io_monitor_enable;
    logic [3:0]  io_range_mask;
    logic [15:0] io_range_base;
  } io_range_decode_cfg_t;

  typedef struct packed {
    logic [16:0] mem_range_base;
    logic [6:0]  rsvd;
    logic        mem_monitor_enable;
    logic [6:0]  mem_range_mask;
  } mem_range_decode_cfg_t;

endpackage : range_decode_pkg

// ---- hdl/range_match.sv ----
`timescale 1ns/1ns
module range_match #(
  parameter int BW = 16,
  parameter int MW = 4
) (
  range_match_if.cmp m
);

  // Mask bits cover only the low end of the span; upper base bits always count
  wire [BW-1:0] ignore_bits = {{(BW-MW){1'b0}}, m.mask};
  wire [BW-1:0] diff_bits   = (m.addr ^ m.base) & ~ignore_bits;

  assign m.hit = m.enable && (diff_bits == {BW{1'b0}});

endmodule : range_match

// ---- hdl/range_match_if.sv ----
`timescale 1ns/1ns
interface range_match_if #(parameter int BW = 16, parameter int MW = 4);
  logic          enable;
  logic [BW-1:0] base;
  logic [BW-1:0] addr;
  logic [MW-1:0] mask;
  logic          hit;

  modport cmp  (input enable, base, addr, mask, output hit);
  modport user (output enable, base, addr, mask, input hit);
endinterface : range_match_if
